// [common/flash_host_pkg.sv]
package flash_host_pkg;
  // ==========================================================
  // Command codes written to the device
  localparam logic [7:0] CMD_PROGRAM_SETUP = 8'h40;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_ERASE_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  // ==========================================================
  // Status bit positions
  localparam int ENGINE_READY_BIT = 7;
  localparam int ERASE_FAIL_BIT = 5;
  localparam int PROGRAM_FAIL_BIT = 4;
  localparam int SUPPLY_LOW_BIT = 3;
  // ==========================================================
  // Bus strobe timing, in ns and cycles at 50 MHz
  localparam int CLK_PERIOD_NS = 20;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYCLES =
    (STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Override settle time before the setup write
  localparam int OVERRIDE_SETTLE_NS = 480;
  localparam int OVERRIDE_CYCLES =
    (OVERRIDE_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TIMER_W = 6;
  // ==========================================================
  // Sequencer states, Gray in the order listed
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0000,
    ST_RAISE = 4'b0001,
    ST_SETUP = 4'b0011,
    ST_CONFIRM = 4'b0010,
    ST_POLL = 4'b0110,
    ST_CHECK = 4'b0111,
    ST_CLEAR = 4'b0101,
    ST_ARRAY = 4'b0100,
    ST_DONE = 4'b1100
  } seq_state_t;
  // Bus cycle phases
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACTIVE = 2'b01,
    BUS_GAP = 2'b11
  } bus_phase_t;
endpackage

// [design/flash_bus_cycle.sv]
`timescale 1ns/100ps
// ==========================================================
// One asynchronous write or read cycle on the flash pins
module flash_bus_cycle
  import flash_host_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstSync_n,
  // Request
  input wire logic start,
  input wire logic isWrite,
  input wire logic [16:0] addrIn,
  input wire logic [7:0] dataIn,
  output logic done,
  output logic [7:0] readData,
  // Pins
  output logic [16:0] flashAddr,
  output logic [7:0] dqOut,
  output logic dqOe,
  input wire logic [7:0] dqIn,
  output logic chipSel_n,
  output logic writeEn_n,
  output logic readStrobe_n
);
  typedef struct packed {
    bus_phase_t phase;
    logic [TIMER_W-1:0] timer;
    logic write;
    logic [16:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic doneP;
  } bus_t;
  bus_t cur, next_cur;

  // Strobe low for STROBE_CYCLES + 1 cycles, then an idle gap as long so each read
  // is a fresh strobe and the status is refreshed
  always_comb begin
    next_cur = cur;
    next_cur.doneP = 1'b0;
    case (cur.phase)
      BUS_IDLE: begin
        if (start) begin
          next_cur.phase = BUS_ACTIVE;
          next_cur.timer = TIMER_W'(STROBE_CYCLES);
          next_cur.write = isWrite;
          next_cur.addr = addrIn;
          next_cur.wdata = dataIn;
        end
      end
      BUS_ACTIVE: begin
        if (cur.timer == '0) begin
          if (!cur.write) next_cur.rdata = dqIn;
          next_cur.phase = BUS_GAP;
          next_cur.timer = TIMER_W'(STROBE_CYCLES);
        end else begin
          next_cur.timer = cur.timer - 1'b1;
        end
      end
      default: begin
        if (cur.timer == '0) begin
          next_cur.phase = BUS_IDLE;
          next_cur.doneP = 1'b1;
        end else begin
          next_cur.timer = cur.timer - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) cur <= '0;
    else cur <= next_cur;
  end

  // Pin drive; data held through the gap so it is stable at WE rise
  assign flashAddr = cur.addr;
  assign dqOut = cur.wdata;
  assign dqOe = cur.write && cur.phase != BUS_IDLE;
  assign chipSel_n = cur.phase != BUS_ACTIVE;
  assign writeEn_n = !(cur.phase == BUS_ACTIVE && cur.write);
  assign readStrobe_n = !(cur.phase == BUS_ACTIVE && !cur.write);
  assign done = cur.doneP;
  assign readData = cur.rdata;
endmodule // flash_bus_cycle

// [design/flash_boot_host.sv]
`timescale 1ns/100ps
module flash_boot_host
  import flash_host_pkg::*;
#(
  parameter logic [16:0] BOOT_BASE = 17'h1e000,
  parameter logic [16:0] BOOT_LAST = 17'h1ffff
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_n,
  // User command port
  input wire logic opStart,
  input wire logic opErase,
  input wire logic opLast,
  input wire logic fullCheck,
  input wire logic [16:0] opAddr,
  input wire logic [7:0] opData,
  output logic opBusy,
  output logic opDone,
  output logic opFail,
  output logic [7:0] opStatus,
  // Flash pins
  output logic [16:0] flashAddr,
  output logic [7:0] dqOut,
  output logic dqOe,
  input wire logic [7:0] dqIn,
  output logic chipSel_n,
  output logic writeEn_n,
  output logic readStrobe_n,
  output logic overrideEnable
);
  // ==========================================================
  // Reset synchroniser
  logic [1:0] rstPipe;
  logic rstSync_n;
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) rstPipe <= 2'b00;
    else rstPipe <= {rstPipe[0], 1'b1};
  end
  assign rstSync_n = rstPipe[1];

  // ==========================================================
  // State
  typedef struct packed {
    seq_state_t state;
    logic erase;
    logic last;
    logic check;
    logic [16:0] addr;
    logic [7:0] data;
    logic boot;
    logic override;
    logic [TIMER_W-1:0] wait_;
    logic issued;
    logic [7:0] status;
    logic fail;
    logic doneP;
  } host_t;
  host_t cur, next_cur;

  logic busStart, busWrite, busDone;
  logic [7:0] busData;
  logic [7:0] busRead;
  logic [16:0] busAddr;
  logic inBoot;

  // Lock check is only needed for the boot range
  assign inBoot = opAddr >= BOOT_BASE && opAddr <= BOOT_LAST;

  // ==========================================================
  // Sequencer
  always_comb begin
    next_cur = cur;
    next_cur.doneP = 1'b0;
    busStart = 1'b0;
    busWrite = 1'b1;
    busAddr = cur.addr;
    busData = cur.data;
    case (cur.state)
      ST_IDLE: begin
        if (opStart) begin
          next_cur.erase = opErase;
          next_cur.last = opLast;
          next_cur.check = fullCheck;
          next_cur.addr = opAddr;
          next_cur.data = opData;
          next_cur.boot = inBoot;
          next_cur.fail = 1'b0;
          next_cur.issued = 1'b0;
          next_cur.wait_ = TIMER_W'(OVERRIDE_CYCLES);
          // Drive straight to override, never a middle level
          next_cur.override = inBoot;
          next_cur.state = ST_RAISE;
        end
      end
      // Let override settle before the setup write
      ST_RAISE: begin
        if (cur.wait_ == '0) next_cur.state = ST_SETUP;
        else next_cur.wait_ = cur.wait_ - 1'b1;
      end
      ST_SETUP: begin
        busStart = !cur.issued;
        busData = cur.erase ? CMD_ERASE_SETUP : CMD_PROGRAM_SETUP;
        next_cur.issued = 1'b1;
        if (busDone) begin
          next_cur.issued = 1'b0;
          next_cur.state = ST_CONFIRM;
        end
      end
      ST_CONFIRM: begin
        busStart = !cur.issued;
        busData = cur.erase ? CMD_ERASE_CONFIRM : cur.data;
        next_cur.issued = 1'b1;
        if (busDone) begin
          next_cur.issued = 1'b0;
          next_cur.state = ST_POLL;
        end
      end
      // Each poll is its own strobe so status refreshes
      ST_POLL: begin
        busStart = !cur.issued;
        busWrite = 1'b0;
        next_cur.issued = 1'b1;
        if (busDone) begin
          next_cur.issued = 1'b0;
          next_cur.status = busRead;
          if (busRead[ENGINE_READY_BIT]) next_cur.state = ST_CHECK;
        end
      end
      ST_CHECK: begin
        // Override held until ready was seen; release now
        next_cur.override = 1'b0;
        if (cur.check || cur.last) begin
          next_cur.fail = cur.status[PROGRAM_FAIL_BIT]
                        | cur.status[ERASE_FAIL_BIT]
                        | cur.status[SUPPLY_LOW_BIT];
        end
        // Unchecked bytes keep their error bits for the final check
        if ((cur.check || cur.last) && (cur.status[SUPPLY_LOW_BIT] ||
            cur.status[PROGRAM_FAIL_BIT] ||
            cur.status[ERASE_FAIL_BIT])) begin
          next_cur.state = ST_CLEAR;
        end else if (cur.last) begin
          next_cur.state = ST_ARRAY;
        end else begin
          next_cur.state = ST_DONE;
        end
      end
      ST_CLEAR: begin
        busStart = !cur.issued;
        busData = CMD_CLEAR_STATUS;
        next_cur.issued = 1'b1;
        if (busDone) begin
          next_cur.issued = 1'b0;
          next_cur.state = cur.last ? ST_ARRAY : ST_DONE;
        end
      end
      ST_ARRAY: begin
        busStart = !cur.issued;
        busData = CMD_READ_ARRAY;
        next_cur.issued = 1'b1;
        if (busDone) begin
          next_cur.issued = 1'b0;
          next_cur.state = ST_DONE;
        end
      end
      default: begin
        next_cur.doneP = 1'b1;
        next_cur.state = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstSync_n) begin
    if (!rstSync_n) cur <= '0;
    else cur <= next_cur;
  end

  // ==========================================================
  // Bus cycle engine
  flash_bus_cycle busCycle (
    .sys_clk(sys_clk),
    .rstSync_n(rstSync_n),
    .start(busStart),
    .isWrite(busWrite),
    .addrIn(busAddr),
    .dataIn(busData),
    .done(busDone),
    .readData(busRead),
    .flashAddr(flashAddr),
    .dqOut(dqOut),
    .dqOe(dqOe),
    .dqIn(dqIn),
    .chipSel_n(chipSel_n),
    .writeEn_n(writeEn_n),
    .readStrobe_n(readStrobe_n)
  );

  // User outputs
  assign opBusy = cur.state != ST_IDLE;
  assign opDone = cur.doneP;
  assign opFail = cur.fail;
  assign opStatus = cur.status;
  assign overrideEnable = cur.override;
endmodule // flash_boot_host

// [sim/flash_boot_props.sv]
`timescale 1ns/100ps
// ==========
// Pin and handshake checks
module flash_boot_props
  import flash_host_pkg::*;
#(
  parameter logic [16:0] BOOT_BASE = 17'h1e000
) (
  // Clock, reset, user side
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic opStart,
  input wire logic opBusy,
  input wire logic opDone,
  // Flash pins
  input wire logic [16:0] flashAddr,
  input wire logic [7:0] dqOut,
  input wire logic dqOe,
  input wire logic chipSel_n,
  input wire logic writeEn_n,
  input wire logic readStrobe_n,
  input wire logic overrideEnable
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  // Strobe low six cycles, then high
  sequence wrHeld; !writeEn_n [*6] ##1 writeEn_n; endsequence
  sequence rdHeld; !readStrobe_n [*6] ##1 readStrobe_n; endsequence
  write_pulse_a: assert property ($fell(writeEn_n) |-> wrHeld)
    else $error("write strobe width wrong");
  read_pulse_a: assert property ($fell(readStrobe_n) |-> rdHeld)
    else $error("read strobe width wrong");
  write_select_a: assert property (!writeEn_n |-> !chipSel_n && dqOe)
    else $error("write without select or drive");
  strobe_excl_a: assert property (writeEn_n || readStrobe_n)
    else $error("read and write strobes together");
  write_stable_a: assert property (!writeEn_n && !$past(writeEn_n)
    |-> $stable(flashAddr) && $stable(dqOut))
    else $error("address or data moved in write");
  boot_confirm_a: assert property (!writeEn_n && flashAddr >= BOOT_BASE
    && dqOut == CMD_ERASE_CONFIRM |-> overrideEnable)
    else $error("boot confirm without override");
  busy_start_a: assert property (opStart && !opBusy |=> opBusy)
    else $error("start not taken");
  done_pulse_a: assert property (opDone |=> !opDone && !opBusy)
    else $error("done not a pulse");
  override_idle_a: assert property (!opBusy |-> !overrideEnable)
    else $error("override left raised");
endmodule // flash_boot_props

bind flash_boot_host flash_boot_props #(.BOOT_BASE(BOOT_BASE)) props (
  .sys_clk, .rst_n, .opStart, .opBusy, .opDone, .flashAddr, .dqOut,
  .dqOe, .chipSel_n, .writeEn_n, .readStrobe_n, .overrideEnable);

// [sim/flash_dev_model.sv]
`timescale 1ns/100ps
// ==========
// Behavioural flash device
module flash_dev_model
  import flash_host_pkg::*;
#(
  parameter logic [16:0] BOOT_BASE = 17'h1e000
) (
  // Clock and bench controls
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [7:0] busyLen,
  input wire logic lockStuck,
  input wire logic failNext,
  input wire logic supplyLow,
  // Flash pins
  input wire logic [16:0] flashAddr,
  input wire logic [7:0] dqOut,
  input wire logic chipSel_n,
  input wire logic writeEn_n,
  input wire logic readStrobe_n,
  input wire logic overrideEnable,
  output logic [7:0] dqIn
);
  logic [7:0] status, lastOut, progData, wData;
  logic [16:0] progAddr, wAddr;
  logic statusMode, wrHeld, setP, setE, overrideLost, boot;
  int busy;
  // Released bus shows the inverse, so no stale value reads as good
  assign dqIn = (!chipSel_n && !readStrobe_n) ?
    (statusMode ? status : wAddr[7:0]) : ~lastOut;
  assign boot = wAddr >= BOOT_BASE;
  // Commands decoded as the write strobe rises
  always @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      status <= 8'h80;
      {statusMode, wrHeld, setP, setE, overrideLost} <= '0;
      busy <= 0;
      lastOut <= 8'h00;
    end else begin
      wrHeld <= !writeEn_n && !chipSel_n;
      if (!writeEn_n) begin
        wAddr <= flashAddr;
        wData <= dqOut;
      end
      if (!readStrobe_n)
        lastOut <= dqIn;
      if (busy > 0) begin
        busy <= busy - 1;
        if (boot && !overrideEnable)
          overrideLost <= 1'b1;
        if (busy == 1)
          status[ENGINE_READY_BIT] <= 1'b1;
      end
      if (wrHeld && writeEn_n) begin
        setP <= 1'b0;
        setE <= 1'b0;
        if (setP || (setE && wData == CMD_ERASE_CONFIRM)) begin
          statusMode <= 1'b1;
          if (status[SUPPLY_LOW_BIT] || supplyLow)
            status[SUPPLY_LOW_BIT] <= 1'b1;
          else if (boot && (lockStuck || !overrideEnable))
            status[setE ? ERASE_FAIL_BIT : PROGRAM_FAIL_BIT] <= 1'b1;
          else begin
            busy <= busyLen;
            status[ENGINE_READY_BIT] <= 1'b0;
            if (failNext)
              status[PROGRAM_FAIL_BIT] <= 1'b1;
            progAddr <= wAddr;
            progData <= setE ? 8'hff : wData;
          end
        end else if (setE)
          status[5:4] <= 2'b11;
        else case (wData)
          CMD_PROGRAM_SETUP: setP <= 1'b1;
          CMD_ERASE_SETUP: setE <= 1'b1;
          CMD_READ_ARRAY: statusMode <= 1'b0;
          CMD_CLEAR_STATUS: status[5:3] <= 3'b000;
          default: ;
        endcase
      end
    end
  end
endmodule // flash_dev_model

// [sim/flash_boot_host_bench.sv]
`timescale 1ns/100ps
module flash_boot_host_bench;
  import flash_host_pkg::*;
  logic sys_clk = 0, rst_n = 0, opStart = 0, opErase = 0, opLast = 0;
  logic fullCheck = 0, lockStuck = 0, failNext = 0, supplyLow = 0;
  logic [16:0] opAddr = '0, flashAddr;
  logic [7:0] opData = '0, busyLen = 8'h03, dqOut, dqIn, opStatus;
  logic opBusy, opDone, opFail, dqOe, chipSel_n, writeEn_n;
  logic readStrobe_n, overrideEnable;
  int errors = 0, checks_done = 0;
  flash_boot_host uut (.sys_clk, .rst_n, .opStart, .opErase, .opLast,
    .fullCheck, .opAddr, .opData, .opBusy, .opDone, .opFail, .opStatus,
    .flashAddr, .dqOut, .dqOe, .dqIn, .chipSel_n, .writeEn_n,
    .readStrobe_n, .overrideEnable);
  flash_dev_model dev (.sys_clk, .rst_n, .busyLen, .lockStuck, .failNext,
    .supplyLow, .flashAddr, .dqOut, .chipSel_n, .writeEn_n,
    .readStrobe_n, .overrideEnable, .dqIn);
  // Clock, 20 ns period
  always #10 sys_clk = ~sys_clk;
  // ==========
  // Shared tasks
  task automatic chk(string n, logic [16:0] e, logic [16:0] g);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic runOp(logic e, l, f, logic [16:0] a, logic [7:0] d);
    int n;
    n = 0;
    opErase <= e;
    opLast <= l;
    fullCheck <= f;
    opAddr <= a;
    opData <= d;
    opStart <= 1'b1;
    @(posedge sys_clk);
    opStart <= 1'b0;
    while (opDone !== 1'b1 && n < 9000) begin
      @(posedge sys_clk);
      n++;
    end
    chk("opDone", 1, opDone);
    @(posedge sys_clk);
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ==========
  // Scenarios
  task automatic testMain();
    runOp(0, 1, 1, 17'h00123, 8'h5a);
    chk("addr", 17'h00123, dev.progAddr);
    chk("data", 8'h5a, dev.progData);
    chk("opFail", 0, opFail);
    chk("ready", 1, opStatus[ENGINE_READY_BIT]);
    chk("array mode", 0, dev.statusMode);
    $display("main program done");
  endtask
  task automatic testLock();
    lockStuck <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      runOp(i[0], 1, 1, 17'h1e100, 8'h00);
      chk("opFail", 1, opFail);
      chk("lock bit", 1, opStatus[PROGRAM_FAIL_BIT + i]);
    end
    runOp(0, 1, 1, 17'h1dfff, 8'h11);
    chk("opFail", 0, opFail);
    lockStuck <= 1'b0;
    $display("lock done");
  endtask
  task automatic testBoot();
    busyLen <= 8'hc8;
    runOp(1, 1, 1, 17'h1f000, 8'h00);
    chk("opFail", 0, opFail);
    chk("erased", 17'h1f000, dev.progAddr);
    chk("override held", 0, dev.overrideLost);
    chk("override off", 0, overrideEnable);
    busyLen <= 8'h03;
    $display("boot erase done");
  endtask
  task automatic testFail();
    failNext <= 1'b1;
    runOp(0, 0, 1, 17'h00200, 8'h01);
    chk("opFail", 1, opFail);
    runOp(0, 0, 0, 17'h00201, 8'h02);
    chk("unchecked", 0, opFail);
    chk("deferred bit", 1, dev.status[PROGRAM_FAIL_BIT]);
    chk("status mode", 1, dev.statusMode);
    failNext <= 1'b0;
    supplyLow <= 1'b1;
    runOp(0, 1, 1, 17'h00202, 8'h03);
    chk("opFail", 1, opFail);
    chk("supply bit", 1, opStatus[SUPPLY_LOW_BIT]);
    chk("kept bit", 1, opStatus[PROGRAM_FAIL_BIT]);
    supplyLow <= 1'b0;
    runOp(0, 1, 1, 17'h00203, 8'h04);
    chk("after clear", 0, opFail);
    $display("fail paths done");
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    testMain();
    testLock();
    testBoot();
    testFail();
    complete_run();
  end
  // Watchdog well past the longest expected run
  initial begin
    repeat (60000) @(posedge sys_clk);
    errors++;
    complete_run();
  end
endmodule // flash_boot_host_bench
